/* File: inc/amp_regs_pkg.sv */
/*
 Shared constants and types of the amplifier control and diagnostic
 register bank. Assumes a two-wire serial bus slave on a 10 MHz clock.
*/
`default_nettype none
package amp_regs_pkg;
  // Seven-bit slave address; low bits come from the strap
  localparam logic [6:0] DEV_ADDR_BASE = 7'h6c;
  localparam logic [1:0] ADDR_SEL_OFF = 2'h3;
  localparam logic [1:0] STATUS_LAST = 2'h3;
  localparam logic [1:0] CTRL_LAST = 2'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Power-up state: standby, muted, diagnostics off
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;

  typedef struct packed {
    logic mute_thresh_high;
    logic diag_en;
    logic offset_en;
    logic front_gain_16db;
    logic rear_gain_16db;
    logic front_unmute;
    logic rear_unmute;
    logic clip_10pct;
  } ctrl_a_t;

  typedef struct packed {
    logic cur_thresh_low;
    logic spare;
    logic fast_mute;
    logic standby_off;
    logic line_driver_diag;
    logic cur_diag_en;
    logic right_high_eff;
    logic left_high_eff;
  } ctrl_b_t;

  typedef struct packed {
    logic open_current;
    logic permanent;
    logic short_load;
    logic open_or_offset;
    logic short_vcc;
    logic short_gnd;
  } chan_flags_t;

  typedef struct packed {
    logic therm1;
    logic therm2;
    logic therm3;
    logic diag_done;
    chan_flags_t [3:0] chan;
  } diag_in_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
  } link_state_t;
endpackage : amp_regs_pkg
`default_nettype wire

/* File: hw/amp_control_diag_regs.sv */
/*
 Serial-bus slave holding the two control words and serving the four
 diagnostic status bytes of a four-channel power amplifier.
 Assumes the bus clock is much slower than clk (8 clk per bit or more)
 and that the analog fault flags arrive already on the clk domain.
*/
// How it works
// - Address bit 0: write two words, read status
// - Read returns four status bytes in order
// - Word A bit 7: mute threshold high/low
// - Word A bit 6: load diagnostic enable
// - Word A bit 5: offset detection enable
// - Word A bits 4,3: front/rear gain 16 dB
// - Word A bits 2,1: front/rear unmute
// - Word A bit 0: clip detector 10 percent
// - Word B bit 7: low current threshold
// - Word B bit 5: fast muting time
// - Word B bit 4: one releases standby
// - Word B bit 3: line driver diagnostics
// - Word B bit 2: current detection enable
// - Word B bits 1,0: high efficiency pairs
// - Status one bit 7: first thermal warning
// - Status one bit 6: diagnostic cycle finished
// - Bit 5: open load by peak current
// - Bit 4: permanent versus turn-on diagnostic
// - Bits 3,1,0: shorted load, supply, ground
// - Bit 2: open load or offset
// - Status two bit 7: offset detection active
// - Status two low bits: channel two flags
// - Status three top bits echo standby, diagnostics
// - Address 1101100/1101101/1101110 by strap
`timescale 1ns/1ps
`default_nettype none
module amp_control_diag_regs (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Serial bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address strap, decoded
  input wire logic [1:0] addr_sel,
  // Analog fault flags
  input wire amp_regs_pkg::diag_in_t diag,
  // Control words to the amplifier
  output amp_regs_pkg::ctrl_a_t ctrl_a,
  output amp_regs_pkg::ctrl_b_t ctrl_b
);
  import amp_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [1:0] sel_m, sel_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      sel_m <= ADDR_SEL_OFF;
      sel_s <= ADDR_SEL_OFF;
    end else if (ce) begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      sel_m <= addr_sel;
      sel_s <= sel_m;
    end
  end

  logic rise, fall, start, stop;
  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////
  // Status bytes are built live so a read sees current flags
  logic [7:0] db [4];
  logic [6:0] my_addr;
  logic addr_match;

  always_comb begin
    db[0] = {diag.therm1, diag.diag_done, diag.chan[0]};
    db[1] = {ctrl_a.offset_en, 1'b0, diag.chan[1]};
    db[2] = {ctrl_b.standby_off, ctrl_a.diag_en, diag.chan[2]};
    db[3] = {diag.therm2, diag.therm3, diag.chan[3]};
  end

  ////////////////////////////////////////////////////////////////////
  link_state_t state, next_state;
  logic [7:0] shift, next_shift;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic full, next_full;
  logic rnw, next_rnw;
  logic mack, next_mack;
  logic [1:0] wr_idx, next_wr_idx;
  logic [1:0] rd_idx, next_rd_idx;
  logic next_sda_oe;
  ctrl_a_t next_ctrl_a;
  ctrl_b_t next_ctrl_b;
  logic wr_commit, rd_load;
  logic [1:0] load_idx;

  // Compared only once the eighth address bit is in
  assign my_addr = DEV_ADDR_BASE + {5'h00, sel_s};
  assign addr_match = (sel_s != ADDR_SEL_OFF) && (shift[7:1] == my_addr);

  // Only the first two written bytes are stored; extras are refused
  assign wr_commit = (state == ST_WR_BYTE) && fall && full && (wr_idx <= CTRL_LAST);
  assign rd_load = fall && ((state == ST_ADDR_ACK && rnw) || (state == ST_RD_ACK && mack));
  assign load_idx = (state == ST_ADDR_ACK) ? 2'h0 : rd_idx;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_full = full;
    next_rnw = rnw;
    next_mack = mack;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_sda_oe = sda_oe;
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    if (start) begin
      next_state = ST_ADDR;
      next_bit_cnt = 3'h0;
      next_full = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            next_full = (bit_cnt == BIT_LAST);
          end else if (fall && full) begin
            next_full = 1'b0;
            if (state == ST_ADDR) begin
              if (addr_match) begin
                next_state = ST_ADDR_ACK;
                next_sda_oe = 1'b1;
                next_rnw = shift[0];
                next_wr_idx = 2'h0;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              next_state = ST_WR_ACK;
              next_wr_idx = (wr_idx == 2'h3) ? wr_idx : wr_idx + 2'h1;
              if (wr_commit) begin
                next_sda_oe = 1'b1;
                if (wr_idx == 2'h0)
                  next_ctrl_a = ctrl_a_t'(shift);
                else
                  next_ctrl_b = ctrl_b_t'(shift);
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            if (rnw) begin
              next_state = ST_RD_BYTE;
              next_shift = db[load_idx];
              next_sda_oe = ~db[load_idx][7];
              next_rd_idx = load_idx + 2'h1;
            end else begin
              next_state = ST_WR_BYTE;
              next_sda_oe = 1'b0;
            end
            next_bit_cnt = 3'h0;
          end
        end
        ST_WR_ACK: begin
          if (fall) begin
            next_state = ST_WR_BYTE;
            next_sda_oe = 1'b0;
            next_bit_cnt = 3'h0;
          end
        end
        ST_RD_BYTE: begin
          if (fall) begin
            if (bit_cnt == BIT_LAST) begin
              next_state = ST_RD_ACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
              next_bit_cnt = bit_cnt + 3'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (rise) begin
            next_mack = ~sda_s;
          end else if (fall) begin
            next_bit_cnt = 3'h0;
            if (mack) begin
              // Wraps to the first byte after the fourth
              next_state = ST_RD_BYTE;
              next_shift = db[load_idx];
              next_sda_oe = ~db[load_idx][7];
              next_rd_idx = load_idx + 2'h1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      full <= 1'b0;
      rnw <= 1'b0;
      mack <= 1'b0;
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      ctrl_a <= CTRL_A_RST;
      ctrl_b <= CTRL_B_RST;
    end else if (ce) begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      full <= next_full;
      rnw <= next_rnw;
      mack <= next_mack;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_taken;
    ce && state == ST_ADDR && fall && full && addr_match;
  endsequence

  a_addr_ack_drive: assert property (
    s_addr_taken |=> state == ST_ADDR_ACK && sda_oe)
    else $error("address match not acknowledged");

  a_addr_reject: assert property (
    ce && state == ST_ADDR && fall && full && !addr_match |=> state == ST_IDLE && !sda_oe)
    else $error("foreign address acknowledged");

  a_dir_bit: assert property (
    s_addr_taken |=> rnw == $past(shift[0]))
    else $error("direction bit not taken from address");

  a_word_a_load: assert property (
    ce && wr_commit && wr_idx == 2'h0 |=> ctrl_a == $past(shift) && $stable(ctrl_b))
    else $error("first control word not stored");

  a_word_b_load: assert property (
    ce && wr_commit && wr_idx == 2'h1 |=> ctrl_b == $past(shift) && $stable(ctrl_a))
    else $error("second control word not stored");

  a_ctrl_hold: assert property (
    !(ce && wr_commit) |=> $stable(ctrl_a) && $stable(ctrl_b))
    else $error("control word changed without a write");

  a_rd_order: assert property (
    ce && rd_load |=> shift == $past(db[load_idx]) && rd_idx == $past(load_idx) + 2'h1)
    else $error("status byte out of order");

  a_rd_first_byte: assert property (
    ce && rd_load && state == ST_ADDR_ACK |=> shift[7] == $past(diag.therm1)
      && shift[6] == $past(diag.diag_done) && shift[5:0] == $past(diag.chan[0]))
    else $error("first status byte layout wrong");

  a_rd_second_byte: assert property (
    ce && rd_load && load_idx == 2'h1 |=> shift == {$past(ctrl_a.offset_en), 1'b0,
      $past(diag.chan[1])})
    else $error("second status byte layout wrong");

  a_standby_echo: assert property (
    ce && rd_load && load_idx == 2'h2 |=> shift[7:6] == $past({ctrl_b.standby_off,
      ctrl_a.diag_en}))
    else $error("third status byte echo wrong");

  a_bit_drive: assert property (
    state == ST_RD_BYTE |-> sda_oe == ~shift[7])
    else $error("read data bit not on the bus");

  ////////////////////////////////////////////////////////////////////
  // Framing and release checks; a stuck pull-down would hang the bus
  sequence s_wr_extra;
    ce && state == ST_WR_BYTE && fall && full && wr_idx > CTRL_LAST;
  endsequence

  sequence s_rd_bit_last;
    ce && state == ST_RD_BYTE && fall && bit_cnt == BIT_LAST;
  endsequence

  sequence s_host_nack;
    ce && state == ST_RD_ACK && fall && !mack;
  endsequence

  a_start_restart: assert property (
    ce && start |=> state == ST_ADDR && !sda_oe && !full && bit_cnt == 3'h0)
    else $error("start condition did not restart the frame");

  a_stop_idle: assert property (
    ce && stop |=> state == ST_IDLE && !sda_oe)
    else $error("stop condition did not release the bus");

  a_ack_release: assert property (
    ce && fall && (state == ST_WR_ACK || (state == ST_ADDR_ACK && !rnw)) |=> !sda_oe)
    else $error("write acknowledge held past its bit");

  a_extra_nack: assert property (
    s_wr_extra |=> state == ST_WR_ACK && !sda_oe && $stable(ctrl_a) && $stable(ctrl_b))
    else $error("third written byte taken");

  a_rd_release: assert property (
    s_rd_bit_last |=> state == ST_RD_ACK && !sda_oe)
    else $error("data line held into the host acknowledge");

  a_host_nack_end: assert property (
    s_host_nack |=> state == ST_IDLE && !sda_oe)
    else $error("read went on after a refused byte");

  a_rd_wrap: assert property (
    ce && rd_load && load_idx == STATUS_LAST |=> rd_idx == 2'h0)
    else $error("read did not wrap after the fourth byte");

  a_rd_third_chan: assert property (
    ce && rd_load && load_idx == 2'h2 |=> shift[5:0] == $past(diag.chan[2]))
    else $error("third status byte flags wrong");

  a_rd_fourth_byte: assert property (
    ce && rd_load && load_idx == 2'h3 |=> shift == {$past(diag.therm2), $past(diag.therm3),
      $past(diag.chan[3])})
    else $error("fourth status byte layout wrong");

  a_out_low: assert property (
    sda_out == 1'b0)
    else $error("data pin driven high");
endmodule : amp_control_diag_regs
`default_nettype wire

/* File: dv/amp_host_model.sv */
/*
 Host bus master model: drives the clock line and pulls the data line.
 Assumes the bench resolves the wired data level and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_host_model (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda_wire,
  // Host drive, enable high pulls data low
  output logic scl,
  output logic host_oe
);
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // Bus clock stands still between frames; 8 clk per bit
  task automatic bit_xfer(input logic b, output logic r);
    scl = 1'b0;
    repeat (2) @(negedge clk);
    host_oe = ~b;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    r = sda_wire;
    repeat (2) @(negedge clk);
  endtask : bit_xfer
  task automatic start_cond;
    scl = 1'b0;
    repeat (2) @(negedge clk);
    host_oe = 1'b0;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    host_oe = 1'b1;
    repeat (4) @(negedge clk);
  endtask : start_cond
  task automatic stop_cond;
    scl = 1'b0;
    repeat (2) @(negedge clk);
    host_oe = 1'b1;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    host_oe = 1'b0;
    repeat (4) @(negedge clk);
  endtask : stop_cond
  // Address byte carries direction in bit 0
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask : recv_byte
endmodule : amp_host_model
`default_nettype wire

/* File: dv/amp_control_diag_regs_tb.sv */
/*
 Self-checking bench for the control and diagnostic register bank.
 Assumes the host model in the same folder and the shared package.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_control_diag_regs_tb;
  import amp_regs_pkg::*;
  logic clk;
  logic reset_n;
  logic ce;
  logic [1:0] addr_sel;
  diag_in_t diag;
  logic scl;
  logic host_oe;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  ctrl_a_t ctrl_a;
  ctrl_b_t ctrl_b;
  int bad_count = 0;
  int check_count = 0;
  // Open drain with pull-up: either party pulling low wins
  assign sda_wire = ~(sda_oe | host_oe);
  amp_control_diag_regs dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .diag(diag), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b));
  amp_host_model host_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .host_oe(host_oe));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic wr_xfer(input logic [6:0] addr, input int n, input logic [23:0] data,
      output logic [3:0] acks);
    logic k;
    acks = 4'h0;
    host_u.start_cond();
    host_u.send_byte({addr, 1'b0}, k);
    acks[0] = k;
    for (int i = 0; i < n; i++) begin
      host_u.send_byte(data[23-8*i -: 8], k);
      acks[i+1] = k;
    end
    host_u.stop_cond();
  endtask : wr_xfer
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(ctrl_a, 8'h00);
    check(ctrl_b, 8'h00);
    check({7'h0, sda_oe}, 8'h00);
    check({7'h0, sda_out}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // Word B bit 6 kept at zero by the host
  task automatic t_write;
    logic [15:0] pats [2] = '{16'ha53f, 16'h5a80};
    logic [3:0] acks;
    for (int i = 0; i < 2; i++) begin
      wr_xfer(DEV_ADDR_BASE, 3, {pats[i], 8'hff}, acks);
      check({4'h0, acks}, 8'h07);
      check(ctrl_a, pats[i][15:8]);
      check(ctrl_b, pats[i][7:0]);
    end
    // Partial write must leave word B alone
    wr_xfer(DEV_ADDR_BASE, 1, 24'h110000, acks);
    check(ctrl_a, 8'h11);
    check(ctrl_b, 8'h80);
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    diag_in_t pats [2] = '{28'h9a53c69, 28'h65ac396};
    logic [7:0] exp [5];
    logic [7:0] got;
    logic [3:0] acks;
    logic on;
    logic k;
    for (int i = 0; i < 2; i++) begin
      on = (i == 0);
      wr_xfer(DEV_ADDR_BASE, 2, {on ? 16'h6010 : 16'h0000, 8'h00}, acks);
      @(negedge clk);
      diag = pats[i];
      exp[0] = {pats[i].therm1, pats[i].diag_done, pats[i].chan[0]};
      exp[1] = {on, 1'b0, pats[i].chan[1]};
      exp[2] = {on, on, pats[i].chan[2]};
      exp[3] = {pats[i].therm2, pats[i].therm3, pats[i].chan[3]};
      exp[4] = exp[0];
      host_u.start_cond();
      host_u.send_byte({DEV_ADDR_BASE, 1'b1}, k);
      check({7'h0, k}, 8'h01);
      for (int j = 0; j < 5; j++) begin
        host_u.recv_byte(got, j < 4);
        check(got, exp[j]);
      end
      host_u.stop_cond();
    end
    $display("test read done");
  endtask : t_read
  task automatic t_addr;
    logic [3:0] acks;
    logic want;
    for (int s = 0; s < 4; s++) begin
      @(negedge clk);
      addr_sel = s[1:0];
      repeat (4) @(negedge clk);
      for (int a = 0; a < 3; a++) begin
        wr_xfer(DEV_ADDR_BASE + 7'(a), 0, 24'h0, acks);
        want = (s != 3) && (a == s);
        check({7'h0, acks[0]}, {7'h0, want});
      end
    end
    @(negedge clk);
    addr_sel = 2'h0;
    $display("test address done");
  endtask : t_addr
  // Frozen block ignores a whole frame; a mid-run reset clears word A
  task automatic t_freeze;
    logic [3:0] acks;
    @(negedge clk);
    ce = 1'b0;
    wr_xfer(DEV_ADDR_BASE, 2, 24'hffbf00, acks);
    check({4'h0, acks}, 8'h00);
    check(ctrl_a, 8'h00);
    check(ctrl_b, 8'h00);
    @(negedge clk);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    wr_xfer(DEV_ADDR_BASE, 1, 24'h420000, acks);
    check(ctrl_a, 8'h42);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check(ctrl_a, 8'h00);
    check({7'h0, sda_oe}, 8'h00);
    repeat (4) @(negedge clk);
    $display("test freeze done");
  endtask : t_freeze
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    addr_sel = 2'h0;
    diag = '0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_write();
    t_read();
    t_addr();
    t_freeze();
    finish_test();
  end
  // Whole run needs well under a millisecond
  initial begin
    #2000000;
    bad_count++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : amp_control_diag_regs_tb
`default_nettype wire
